// ---- inc/fcs_pkg.sv ----
package fcs_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] FCS_DIV_IDX = 8'h00;
    localparam logic [7:0] FCS_SEC_IDX = 8'h01;
    localparam logic [7:0] FCS_CIX_IDX = 8'h02;
    localparam logic [7:0] FCS_CCH_IDX = 8'h0a;
    localparam logic [7:0] FCS_CCL_IDX = 8'h0b;
    localparam logic [7:0] FCS_RSV_IDX = 8'h0c;
    localparam logic [7:0] FCS_STA_IDX = 8'h06;
    localparam logic [7:0] FCS_DIV_ADDR = 8'(FCS_DIV_IDX * 4);
    localparam logic [7:0] FCS_SEC_ADDR = 8'(FCS_SEC_IDX * 4);
    localparam logic [7:0] FCS_CIX_ADDR = 8'(FCS_CIX_IDX * 4);
    localparam logic [7:0] FCS_CCH_ADDR = 8'(FCS_CCH_IDX * 4);
    localparam logic [7:0] FCS_CCL_ADDR = 8'(FCS_CCL_IDX * 4);
    localparam logic [7:0] FCS_RSV_ADDR = 8'(FCS_RSV_IDX * 4);
    localparam logic [7:0] FCS_STA_ADDR = 8'(FCS_STA_IDX * 4);
    // Field positions
    localparam int FCS_WRITTEN_BIT = 7;
    localparam int FCS_LOCK_BIT = 6;
    localparam int FCS_COMMAND_COMPLETE_FLAG_BIT = 7;
    // Values after reset
    localparam logic [7:0] FCS_DIV_RESET = 8'h00;
    localparam logic [7:0] FCS_SEC_RESET = 8'hff;
    localparam logic [1:0] FCS_CIX_RESET = 2'h0;
    localparam logic [15:0] FCS_CCOB_RESET = 16'h0000;
    // Codes
    localparam logic [1:0] FCS_KEY_ENABLED = 2'h2;
    localparam logic [1:0] FCS_UNSECURED = 2'h2;
    localparam logic [7:0] FCS_FAULT_SEC = 8'hff;
    localparam int FCS_CCOB_WORDS = 4;

    typedef struct packed {
        logic written;
        logic lock;
        logic [5:0] div;
    } fcs_div_t;

    typedef struct packed {
        logic [1:0] key_en;
        logic [3:0] spare;
        logic [1:0] state;
    } fcs_sec_t;

    typedef enum logic [1:0] {
        FCS_SEQ_RESET = 2'b00,
        FCS_SEQ_IDLE = 2'b01,
        FCS_SEQ_BUSY = 2'b11
    } fcs_seq_t;
endpackage : fcs_pkg

// ---- rtl/fcs_regs.sv ----
// Design decision made here: the APB register port.
`timescale 1ns/10ps
// Contract
// - Divider-written flag reads 1 after any divider register write since reset, else 0.
// - Divider bits all readable; bit 7 ignores writes; bit 6 sets once, gates field.
// - With lock set the divider field holds; only reset clears the lock.
// - Bus clock is divided by the divider field plus one to give a 1 MHz timebase.
// - Divider register accepts writes during the reset sequence.
// - Protection register is readable and ignores all software writes.
// - Reset sequence loads the protection register from the nonvolatile security byte.
// - Double-bit fault on that load sets every protection bit.
// - Backdoor enable field permits key access only for code 10.
// - Protection state field means unsecured only for code 10.
// - Backdoor unsecure forces the protection state field to 10 outside the reset sequence.
// - Command word index selects the command object word reached by accesses.
// - Index register: only index bits read and write; others read 0.
// - Factory-test register reads zero and ignores writes.
// - Command-complete flag reads 0 during the reset sequence and while a command is active, else 1.
module fcs_regs (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic NV_VALID,
    input wire logic [7:0] NV_SEC_BYTE,
    input wire logic NV_DOUBLE_FAULT,
    input wire logic BACKDOOR_UNSECURE,
    input wire logic CMD_START,
    input wire logic CMD_DONE,
    output logic CMD_COMPLETE,
    output logic TIMEBASE_TICK,
    output logic SECURED,
    output logic BACKDOOR_KEY_ENABLED,
    output logic [1:0] CCOB_INDEX,
    output logic [15:0] CCOB_WORD
);
    fcs_pkg::fcs_div_t div_reg;
    fcs_pkg::fcs_div_t next_div_reg;
    fcs_pkg::fcs_sec_t sec_reg;
    fcs_pkg::fcs_sec_t next_sec_reg;
    fcs_pkg::fcs_seq_t seq;
    fcs_pkg::fcs_seq_t next_seq;
    logic [1:0] cix;
    logic [1:0] next_cix;
    logic [15:0] ccob [fcs_pkg::FCS_CCOB_WORDS];
    logic [15:0] next_ccob [fcs_pkg::FCS_CCOB_WORDS];
    logic [5:0] cnt;
    logic [5:0] next_cnt;
    logic next_tick;
    logic next_pready;
    logic next_pslverr;
    logic [31:0] next_prdata;
    logic setup_ok;
    logic wr_done;
    logic mapped;
    logic [7:0] rd_byte;

    assign setup_ok = PSEL && PENABLE && !PREADY;
    assign wr_done = PSEL && PENABLE && PREADY && PWRITE;

    // Address decode and read mux
    always_comb begin
        mapped = 1'b1;
        rd_byte = 8'h00;
        case (PADDR)
            fcs_pkg::FCS_DIV_ADDR: rd_byte = div_reg;
            fcs_pkg::FCS_SEC_ADDR: rd_byte = sec_reg;
            fcs_pkg::FCS_CIX_ADDR: rd_byte = {6'h00, cix};
            fcs_pkg::FCS_CCH_ADDR: rd_byte = ccob[cix][15:8];
            fcs_pkg::FCS_CCL_ADDR: rd_byte = ccob[cix][7:0];
            fcs_pkg::FCS_RSV_ADDR: rd_byte = 8'h00;
            fcs_pkg::FCS_STA_ADDR: rd_byte = {seq == fcs_pkg::FCS_SEQ_IDLE, 7'h00};
            default: mapped = 1'b0;
        endcase
    end

    // Bus answer one cycle into the access phase
    always_comb begin
        next_pready = setup_ok;
        next_prdata = PRDATA;
        next_pslverr = 1'b0;
        if (setup_ok) begin
            next_prdata = PWRITE ? 32'h00000000 : {24'h000000, rd_byte};
            next_pslverr = !mapped;
        end
    end

    // Register writes
    always_comb begin
        next_div_reg = div_reg;
        next_cix = cix;
        next_ccob = ccob;
        if (wr_done) begin
            case (PADDR)
                fcs_pkg::FCS_DIV_ADDR: begin
                    // Accepted in every sequencer state, reset sequence included
                    next_div_reg.written = 1'b1;
                    if (!div_reg.lock) begin
                        next_div_reg.div = PWDATA[5:0];
                    end
                    next_div_reg.lock = div_reg.lock | PWDATA[fcs_pkg::FCS_LOCK_BIT];
                end
                fcs_pkg::FCS_CIX_ADDR: next_cix = PWDATA[1:0];
                fcs_pkg::FCS_CCH_ADDR: next_ccob[cix][15:8] = PWDATA[7:0];
                fcs_pkg::FCS_CCL_ADDR: next_ccob[cix][7:0] = PWDATA[7:0];
                default: next_cix = cix;
            endcase
        end
    end

    // Reset sequence, protection load and command activity
    always_comb begin
        next_seq = seq;
        next_sec_reg = sec_reg;
        case (seq)
            fcs_pkg::FCS_SEQ_RESET: begin
                if (NV_VALID) begin
                    next_seq = fcs_pkg::FCS_SEQ_IDLE;
                    next_sec_reg = NV_DOUBLE_FAULT ? fcs_pkg::FCS_FAULT_SEC : NV_SEC_BYTE;
                end
            end
            fcs_pkg::FCS_SEQ_IDLE: begin
                if (CMD_START) begin
                    next_seq = fcs_pkg::FCS_SEQ_BUSY;
                end
            end
            fcs_pkg::FCS_SEQ_BUSY: begin
                if (CMD_DONE) begin
                    next_seq = fcs_pkg::FCS_SEQ_IDLE;
                end
            end
            default: next_seq = fcs_pkg::FCS_SEQ_RESET;
        endcase
        if (BACKDOOR_UNSECURE && seq != fcs_pkg::FCS_SEQ_RESET) begin
            next_sec_reg.state = fcs_pkg::FCS_UNSECURED;
        end
    end

    // Timebase divider, running once the divider has been loaded
    always_comb begin
        next_cnt = 6'h00;
        next_tick = 1'b0;
        if (div_reg.written) begin
            if (cnt >= div_reg.div) begin
                next_tick = 1'b1;
            end else begin
                next_cnt = cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            div_reg <= fcs_pkg::FCS_DIV_RESET;
            sec_reg <= fcs_pkg::FCS_SEC_RESET;
            seq <= fcs_pkg::FCS_SEQ_RESET;
            cix <= fcs_pkg::FCS_CIX_RESET;
            for (int i = 0; i < fcs_pkg::FCS_CCOB_WORDS; i++) begin
                ccob[i] <= fcs_pkg::FCS_CCOB_RESET;
            end
            cnt <= 6'h00;
            TIMEBASE_TICK <= 1'b0;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
            CMD_COMPLETE <= 1'b0;
            SECURED <= 1'b1;
            BACKDOOR_KEY_ENABLED <= 1'b0;
            CCOB_INDEX <= fcs_pkg::FCS_CIX_RESET;
            CCOB_WORD <= fcs_pkg::FCS_CCOB_RESET;
        end else begin
            div_reg <= next_div_reg;
            sec_reg <= next_sec_reg;
            seq <= next_seq;
            cix <= next_cix;
            ccob <= next_ccob;
            cnt <= next_cnt;
            TIMEBASE_TICK <= next_tick;
            PREADY <= next_pready;
            PSLVERR <= next_pslverr;
            PRDATA <= next_prdata;
            CMD_COMPLETE <= next_seq == fcs_pkg::FCS_SEQ_IDLE;
            SECURED <= next_sec_reg.state != fcs_pkg::FCS_UNSECURED;
            BACKDOOR_KEY_ENABLED <= next_sec_reg.key_en == fcs_pkg::FCS_KEY_ENABLED;
            CCOB_INDEX <= next_cix;
            CCOB_WORD <= next_ccob[next_cix];
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    // Cycles since the last tick, for the period check
    logic [5:0] gap;
    logic [5:0] next_gap;
    logic gap_valid;
    logic next_gap_valid;

    always_comb begin
        next_gap = gap;
        next_gap_valid = gap_valid;
        if (TIMEBASE_TICK) begin
            next_gap = 6'h00;
            next_gap_valid = div_reg.lock;
        end else if (gap != 6'h3f) begin
            next_gap = gap + 6'h01;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            gap <= 6'h00;
            gap_valid <= 1'b0;
        end else begin
            gap <= next_gap;
            gap_valid <= next_gap_valid;
        end
    end

    property p_written_set;
        wr_done && PADDR == fcs_pkg::FCS_DIV_ADDR |=> div_reg.written ##1 div_reg.written;
    endproperty
    a_written_set: assert property (p_written_set) else $error("Written flag not set");

    property p_lock_once;
        wr_done && PADDR == fcs_pkg::FCS_DIV_ADDR && PWDATA[6] |=> div_reg.lock[*3];
    endproperty
    a_lock_once: assert property (p_lock_once) else $error("Lock did not set and stay");

    property p_lock_holds;
        div_reg.lock |=> $stable(div_reg.div) && div_reg.lock;
    endproperty
    a_lock_holds: assert property (p_lock_holds) else $error("Locked divider changed");

    property p_tick_period;
        TIMEBASE_TICK && gap_valid |-> gap == div_reg.div;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("Timebase period wrong");

    property p_sec_ro;
        wr_done && seq != fcs_pkg::FCS_SEQ_RESET && !BACKDOOR_UNSECURE |=> $stable(sec_reg);
    endproperty
    a_sec_ro: assert property (p_sec_ro) else $error("Protection register changed by write");

    property p_sec_load;
        seq == fcs_pkg::FCS_SEQ_RESET && NV_VALID && !NV_DOUBLE_FAULT
            |=> sec_reg == $past(NV_SEC_BYTE) && CMD_COMPLETE;
    endproperty
    a_sec_load: assert property (p_sec_load) else $error("Security byte not loaded");

    property p_sec_fault;
        seq == fcs_pkg::FCS_SEQ_RESET && NV_VALID && NV_DOUBLE_FAULT
            |=> sec_reg == 8'hff ##0 SECURED && !BACKDOOR_KEY_ENABLED;
    endproperty
    a_sec_fault: assert property (p_sec_fault) else $error("Fault did not secure");

    property p_key_map;
        BACKDOOR_KEY_ENABLED == (sec_reg.key_en == 2'h2);
    endproperty
    a_key_map: assert property (p_key_map) else $error("Key enable decode wrong");

    property p_backdoor;
        BACKDOOR_UNSECURE && seq != fcs_pkg::FCS_SEQ_RESET |=> sec_reg.state == 2'h2 && !SECURED;
    endproperty
    a_backdoor: assert property (p_backdoor) else $error("Backdoor did not unsecure");

    property p_cix_read;
        PREADY && !PWRITE && PADDR == fcs_pkg::FCS_CIX_ADDR |-> PRDATA[31:2] == 30'h0;
    endproperty
    a_cix_read: assert property (p_cix_read) else $error("Index upper bits not zero");

    property p_rsv_read;
        PREADY && PADDR == fcs_pkg::FCS_RSV_ADDR |-> PRDATA == 32'h0 && !PSLVERR;
    endproperty
    a_rsv_read: assert property (p_rsv_read) else $error("Reserved register not zero");

    property p_command_complete_flag;
        seq == fcs_pkg::FCS_SEQ_IDLE && CMD_START |=> !CMD_COMPLETE;
    endproperty
    a_command_complete_flag: assert property (p_command_complete_flag) else $error("Complete flag high while busy");

    property p_div_reset;
        !div_reg.written |-> div_reg == fcs_pkg::FCS_DIV_RESET;
    endproperty
    a_div_reset: assert property (p_div_reset) else $error("Divider not clear before write");

    property p_div_open;
        wr_done && PADDR == fcs_pkg::FCS_DIV_ADDR && !div_reg.lock
            |=> div_reg.div == $past(PWDATA[5:0]);
    endproperty
    a_div_open: assert property (p_div_open) else $error("Open divider field not written");

    property p_reset_seq_write;
        wr_done && PADDR == fcs_pkg::FCS_DIV_ADDR && seq == fcs_pkg::FCS_SEQ_RESET
            |=> div_reg.written;
    endproperty
    a_reset_seq_write: assert property (p_reset_seq_write) else $error("Divider write lost");

    property p_cix_write;
        wr_done && PADDR == fcs_pkg::FCS_CIX_ADDR |=> CCOB_INDEX == $past(PWDATA[1:0]);
    endproperty
    a_cix_write: assert property (p_cix_write) else $error("Index not written");

    property p_word_low;
        wr_done && PADDR == fcs_pkg::FCS_CCL_ADDR |=> CCOB_WORD[7:0] == $past(PWDATA[7:0]);
    endproperty
    a_word_low: assert property (p_word_low) else $error("Indexed word not written");

    property p_command_complete_flag_done;
        seq == fcs_pkg::FCS_SEQ_BUSY && CMD_DONE |=> CMD_COMPLETE;
    endproperty
    a_command_complete_flag_done: assert property (p_command_complete_flag_done) else $error("Complete flag low when idle");

    property p_tick_idle;
        !div_reg.written |-> !TIMEBASE_TICK;
    endproperty
    a_tick_idle: assert property (p_tick_idle) else $error("Tick before divider written");

    property p_rsv_write;
        wr_done && PADDR == fcs_pkg::FCS_RSV_ADDR |=> $stable(div_reg) && $stable(cix);
    endproperty
    a_rsv_write: assert property (p_rsv_write) else $error("Reserved write changed state");

    property p_sec_write;
        wr_done && PADDR == fcs_pkg::FCS_SEC_ADDR && !NV_VALID && !BACKDOOR_UNSECURE
            |=> $stable(sec_reg);
    endproperty
    a_sec_write: assert property (p_sec_write) else $error("Protection register written");

    property p_sec_map;
        SECURED == (sec_reg.state != fcs_pkg::FCS_UNSECURED);
    endproperty
    a_sec_map: assert property (p_sec_map) else $error("Secured decode wrong");

    c_div_lock: cover property (wr_done && PADDR == fcs_pkg::FCS_DIV_ADDR && PWDATA[6]);
    c_backdoor: cover property (BACKDOOR_UNSECURE && SECURED);
    c_cmd: cover property (CMD_START ##[1:20] CMD_DONE);
    c_fault: cover property (NV_VALID && NV_DOUBLE_FAULT);
endmodule : fcs_regs

// ---- verification/tb.sv ----
`timescale 1ns/10ps
module tb;
    localparam logic [7:0] A_DIV = fcs_pkg::FCS_DIV_ADDR;
    localparam logic [7:0] A_SEC = fcs_pkg::FCS_SEC_ADDR;
    localparam logic [7:0] A_CIX = fcs_pkg::FCS_CIX_ADDR;
    localparam logic [7:0] A_STA = fcs_pkg::FCS_STA_ADDR;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic nv_valid = 1'b0;
    logic nv_fault = 1'b0;
    logic bd = 1'b0;
    logic cmd_start = 1'b0;
    logic cmd_done = 1'b0;
    logic [7:0] nv_byte = 8'h00;
    logic [31:0] prdata;
    logic pready, pslverr, cmd_complete, tick, secured, key_en;
    logic [1:0] cix;
    logic [15:0] cword;
    logic [31:0] rd;
    logic [31:0] seed = 32'hde77f336;
    logic err;
    logic [5:0] d;
    logic [7:0] b;
    logic [15:0] w [4];
    int n_errors = 0;
    int checks_done = 0;
    int i, j, k;

    always #20 CLK = ~CLK;

    fcs_regs DUT (.CLK(CLK), .RST_N(RST_N), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .NV_VALID(nv_valid), .NV_SEC_BYTE(nv_byte),
        .NV_DOUBLE_FAULT(nv_fault), .BACKDOOR_UNSECURE(bd), .CMD_START(cmd_start),
        .CMD_DONE(cmd_done), .CMD_COMPLETE(cmd_complete), .TIMEBASE_TICK(tick),
        .SECURED(secured), .BACKDOOR_KEY_ENABLED(key_en), .CCOB_INDEX(cix),
        .CCOB_WORD(cword));

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs

    // Recommended divider for a bus clock given in tenths of a MHz
    function automatic logic [7:0] div_for(input int f10);
        return (f10 <= 16) ? 8'h00 : 8'((f10 - 7) / 10);
    endfunction : div_for

    task report_and_stop;
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Setup cycle, then access until pready is seen high at a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [7:0] dat);
        int n;
        @(posedge CLK);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= wr;
        paddr <= a;
        pwdata <= {24'h0, dat};
        @(posedge CLK);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask : rdc

    task do_reset;
        @(posedge CLK);
        RST_N <= 1'b0;
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
    endtask : do_reset

    task load(input logic [7:0] v, input logic f);
        @(posedge CLK);
        nv_valid <= 1'b1;
        nv_byte <= v;
        nv_fault <= f;
        @(posedge CLK);
        nv_valid <= 1'b0;
        nv_fault <= 1'b0;
    endtask : load

    initial begin
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        rdc(A_DIV, 32'h0);
        rdc(A_CIX, 32'h0);
        apb(1'b0, A_STA, 8'h00);
        chk(rd[7], 1'b0);
        // Divider for a 25 MHz bus clock, written during the reset sequence
        b = div_for(250);
        apb(1'b1, A_DIV, b);
        rdc(A_DIV, {24'h0, 8'h80 | b});
        for (i = 0; i < 100 && tick !== 1'b1; i++) @(negedge CLK);
        @(negedge CLK);
        for (j = 1; j < 100 && tick !== 1'b1; j++) @(negedge CLK);
        chk(j, {24'h0, b} + 32'h1);
        for (k = 0; k < 4; k++) begin
            do_reset();
            seed = xs(seed);
            b = {k[1:0], 4'hf, k[1:0]};
            load(b, 1'b0);
            rdc(A_SEC, {24'h0, b});
            chk(secured, k != 2);
            chk(key_en, k == 2);
            apb(1'b1, A_SEC, ~b);
            rdc(A_SEC, {24'h0, b});
        end
        do_reset();
        load(8'h82, 1'b1);
        rdc(A_SEC, 32'hff);
        chk(key_en, 1'b0);
        chk(secured, 1'b1);
        @(posedge CLK) bd <= 1'b1;
        @(posedge CLK) bd <= 1'b0;
        rdc(A_SEC, 32'hfe);
        chk(secured, 1'b0);
        seed = xs(seed);
        d = seed[5:0];
        apb(1'b1, A_DIV, {2'b01, d});
        rdc(A_DIV, {24'h0, 2'b11, d});
        apb(1'b1, A_DIV, {2'b00, ~d});
        rdc(A_DIV, {24'h0, 2'b11, d});
        apb(1'b1, A_CIX, 8'hff);
        rdc(A_CIX, 32'h3);
        for (k = 0; k < 4; k++) begin
            seed = xs(seed);
            w[k] = seed[15:0];
            apb(1'b1, A_CIX, k[7:0]);
            apb(1'b1, fcs_pkg::FCS_CCH_ADDR, w[k][15:8]);
            apb(1'b1, fcs_pkg::FCS_CCL_ADDR, w[k][7:0]);
        end
        for (k = 0; k < 4; k++) begin
            apb(1'b1, A_CIX, k[7:0]);
            @(negedge CLK);
            chk(cix, k[1:0]);
            chk(cword, w[k]);
            rdc(fcs_pkg::FCS_CCH_ADDR, {24'h0, w[k][15:8]});
        end
        apb(1'b1, fcs_pkg::FCS_RSV_ADDR, 8'hff);
        rdc(fcs_pkg::FCS_RSV_ADDR, 32'h0);
        apb(1'b0, 8'hfc, 8'h00);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        @(posedge CLK) cmd_start <= 1'b1;
        @(posedge CLK) cmd_start <= 1'b0;
        apb(1'b0, A_STA, 8'h00);
        chk(rd[7], 1'b0);
        @(posedge CLK) cmd_done <= 1'b1;
        @(posedge CLK) cmd_done <= 1'b0;
        @(negedge CLK);
        chk(cmd_complete, 1'b1);
        report_and_stop();
    end
endmodule : tb
